// file: hw/hbfm_top.sv
`timescale 1ns/1ps
// Functional notes
// - Overcurrent shuts the affected switch off, other switch not gated; enables kept; overcurrent and load bits set
// - High and low switch never on together; dead time between them
// - Thermal warning latches flag, outputs stay active, cleared only by access
// - Thermal shutdown latches all outputs off until flag cleared
// - Enable control bits untouched during thermal warning or shutdown
// - Thermal flags read zero only after clear and condition gone
// - Supply low turns outputs off, latches flag, logic state kept
// - Supply high turns outputs off and latches flag
// - Outputs return automatically when supply recovers; flag stays set
// - Logic supply reset initialises logic and floats all outputs
// - After reset the power-on-reset-not flag reads zero
// - Low current for filter time latches open load; output stays on
// - First two high switches have selectable LED threshold and filter
// - Open load blanked for free-wheeling stages during PWM
// - Latched bits cleared only by read-and-clear access
// - Global fault is OR of status bits, reset-not inverted
module hbfm_top
   import hbfm_pkg::*;
#(
   parameter int OL_FILT_CYC = OL_FILT_US * 200,
   parameter int OL_FILT_LED_CYC = OL_FILT_LED_US * 200
) (
   input wire logic I_SYS_CLK,
   input wire logic I_RESET,
   input wire logic I_CE,
   input wire logic [NUM_HB-1:0] I_HIGH_SWITCH_ENABLE,
   input wire logic [NUM_HB-1:0] I_LOW_SWITCH_ENABLE,
   input wire logic [NUM_HB-1:0] I_HS_PWM_ON,
   input wire logic [NUM_HB-1:0] I_LS_PWM_ON,
   input wire logic [NUM_HB-1:0] I_HS_FREEWHEEL,
   input wire logic [NUM_HB-1:0] I_LS_FREEWHEEL,
   input wire logic [NUM_LED_HS-1:0] I_LED_OL_SEL,
   input wire logic [NUM_HB-1:0] I_HS_OVERCURRENT,
   input wire logic [NUM_HB-1:0] I_LS_OVERCURRENT,
   input wire logic [NUM_HB-1:0] I_HS_UNDERCURRENT,
   input wire logic [NUM_HB-1:0] I_LS_UNDERCURRENT,
   input wire logic [NUM_HB-1:0] I_HS_UNDERCURRENT_LED,
   input wire logic I_TEMP_WARN,
   input wire logic I_TEMP_SHUTDOWN,
   input wire logic I_SUPPLY_LOW,
   input wire logic I_SUPPLY_HIGH,
   input wire logic I_SPI_ERROR,
   input wire logic I_DEVICE_ENABLE,
   input wire logic I_CLEAR_STROBE,
   input wire logic [7:0] I_CLEAR_GLOBAL,
   input wire logic [NUM_HB-1:0] I_CLEAR_HS_OC,
   input wire logic [NUM_HB-1:0] I_CLEAR_LS_OC,
   input wire logic [NUM_HB-1:0] I_CLEAR_HS_OL,
   input wire logic [NUM_HB-1:0] I_CLEAR_LS_OL,
   output logic [NUM_HB-1:0] O_HS_DRIVE,
   output logic [NUM_HB-1:0] O_LS_DRIVE,
   output logic [NUM_HB-1:0] O_HS_DRIVE_OE,
   output logic [NUM_HB-1:0] O_LS_DRIVE_OE,
   output logic [7:0] O_GLOBAL_STATUS_ONE,
   output logic [NUM_HB-1:0] O_HIGH_SWITCH_OVERCURRENT,
   output logic [NUM_HB-1:0] O_LOW_SWITCH_OVERCURRENT,
   output logic [NUM_HB-1:0] O_HIGH_SWITCH_OPEN_LOAD,
   output logic [NUM_HB-1:0] O_LOW_SWITCH_OPEN_LOAD,
   output logic O_GLOBAL_FAULT_FLAG
);
   // ------------------------------------------------------------
   // Latched flags
   // ------------------------------------------------------------
   logic [NUM_HB-1:0] hs_oc_q, ls_oc_q, hs_ol_q, ls_ol_q;
   logic tpw_q, tsd_q, uv_q, ov_q, power_on_reset_not_flag_q, spi_q;
   logic [OL_CNT_W-1:0] hs_cnt_q [NUM_HB];
   logic [OL_CNT_W-1:0] ls_cnt_q [NUM_HB];

   function automatic logic latch_flag(input logic cur, input logic set,
                                       input logic clr);
      // Set beats clear so an event in the clear cycle is kept
      latch_flag = set | (cur & ~clr);
   endfunction

   wire clr = I_CLEAR_STROBE;
   // Only the read-and-clear access strobe clears anything
   wire [NUM_HB-1:0] c_hs_oc = clr ? I_CLEAR_HS_OC : '0;
   wire [NUM_HB-1:0] c_ls_oc = clr ? I_CLEAR_LS_OC : '0;
   wire [NUM_HB-1:0] c_hs_ol = clr ? I_CLEAR_HS_OL : '0;
   wire [NUM_HB-1:0] c_ls_ol = clr ? I_CLEAR_LS_OL : '0;
   wire [7:0] c_gs = clr ? I_CLEAR_GLOBAL : '0;

   // Supply gating is live so recovery needs no software
   wire all_off = tsd_q | I_TEMP_SHUTDOWN | I_SUPPLY_LOW | I_SUPPLY_HIGH;
   // Enable inputs pass through unchanged; faults gate only the stage
   wire [NUM_HB-1:0] hs_req = I_HIGH_SWITCH_ENABLE & I_HS_PWM_ON
      & ~hs_oc_q & ~I_HS_OVERCURRENT & {NUM_HB{~all_off}};
   wire [NUM_HB-1:0] ls_req = I_LOW_SWITCH_ENABLE & I_LS_PWM_ON
      & ~ls_oc_q & ~I_LS_OVERCURRENT & {NUM_HB{~all_off}};
   wire [NUM_HB-1:0] hs_on, ls_on;
   // Gate the registered drive too, else a stage lingers one cycle on
   wire [NUM_HB-1:0] hs_fault_off = hs_oc_q | I_HS_OVERCURRENT
      | {NUM_HB{all_off}};
   wire [NUM_HB-1:0] ls_fault_off = ls_oc_q | I_LS_OVERCURRENT
      | {NUM_HB{all_off}};

   // ------------------------------------------------------------
   // Per-bridge sequencing and open load filters
   // ------------------------------------------------------------
   wire [NUM_HB-1:0] hs_ol_hit, ls_ol_hit;
   for (genvar g = 0; g < NUM_HB; g++) begin : g_hb
      hbfm_leg u_leg (
         .i_clk(I_SYS_CLK),
         .i_rst(I_RESET),
         .i_ce(I_CE),
         .i_hs_req(hs_req[g]),
         .i_ls_req(ls_req[g]),
         .o_hs_on(hs_on[g]),
         .o_ls_on(ls_on[g])
      );
      // LED threshold and short filter on the first two high switches
      wire led = (g < NUM_LED_HS) ? I_LED_OL_SEL[g % NUM_LED_HS] : 1'b0;
      wire hs_low = led ? I_HS_UNDERCURRENT_LED[g]
                        : I_HS_UNDERCURRENT[g];
      wire [OL_CNT_W-1:0] hs_lim = led ? OL_CNT_W'(OL_FILT_LED_CYC - 1)
                                       : OL_CNT_W'(OL_FILT_CYC - 1);
      // Blank the filter while the stage free-wheels
      wire hs_watch = hs_on[g] & hs_low & ~I_HS_FREEWHEEL[g];
      wire ls_watch = ls_on[g] & I_LS_UNDERCURRENT[g] & ~I_LS_FREEWHEEL[g];
      assign hs_ol_hit[g] = hs_watch && hs_cnt_q[g] == hs_lim;
      assign ls_ol_hit[g] = ls_watch &&
         ls_cnt_q[g] == OL_CNT_W'(OL_FILT_CYC - 1);
      always_ff @(posedge I_SYS_CLK) begin
         if (I_RESET) begin
            hs_cnt_q[g] <= '0;
            ls_cnt_q[g] <= '0;
         end else if (I_CE) begin
            if (!hs_watch) begin
               hs_cnt_q[g] <= '0;
            end else if (!hs_ol_hit[g]) begin
               hs_cnt_q[g] <= hs_cnt_q[g] + 1'b1;
            end
            if (!ls_watch) begin
               ls_cnt_q[g] <= '0;
            end else if (!ls_ol_hit[g]) begin
               ls_cnt_q[g] <= ls_cnt_q[g] + 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Flag next values
   // ------------------------------------------------------------
   logic [NUM_HB-1:0] hs_oc_d, ls_oc_d, hs_ol_d, ls_ol_d;
   always_comb begin
      for (int i = 0; i < NUM_HB; i++) begin
         // Persisting fault keeps the flag set through a clear
         hs_oc_d[i] = latch_flag(hs_oc_q[i], I_HS_OVERCURRENT[i] &
            I_HIGH_SWITCH_ENABLE[i], c_hs_oc[i]);
         ls_oc_d[i] = latch_flag(ls_oc_q[i], I_LS_OVERCURRENT[i] &
            I_LOW_SWITCH_ENABLE[i], c_ls_oc[i]);
         hs_ol_d[i] = latch_flag(hs_ol_q[i], hs_ol_hit[i], c_hs_ol[i]);
         ls_ol_d[i] = latch_flag(ls_ol_q[i], ls_ol_hit[i], c_ls_ol[i]);
      end
   end
   wire tpw_d = latch_flag(tpw_q, I_TEMP_WARN, c_gs[GS_TPW]);
   wire tsd_d = latch_flag(tsd_q, I_TEMP_SHUTDOWN, c_gs[GS_TSD]);
   wire uv_d = latch_flag(uv_q, I_SUPPLY_LOW, c_gs[GS_UV]);
   wire ov_d = latch_flag(ov_q, I_SUPPLY_HIGH, c_gs[GS_OV]);
   wire spi_d = latch_flag(spi_q, I_SPI_ERROR, c_gs[GS_SPI]);
   // Reset-not goes high only by a clear in normal mode
   wire power_on_reset_not_flag_d = power_on_reset_not_flag_q | (c_gs[GS_POWER_ON_RESET_NOT_FLAG] & I_DEVICE_ENABLE);
   wire le_d = |{hs_oc_d, ls_oc_d, hs_ol_d, ls_ol_d};
   logic [7:0] gs_d;
   always_comb begin
      gs_d = GS_RESET;
      gs_d[GS_TPW] = tpw_d;
      gs_d[GS_TSD] = tsd_d;
      gs_d[GS_POWER_ON_RESET_NOT_FLAG] = power_on_reset_not_flag_d;
      gs_d[GS_OV] = ov_d;
      gs_d[GS_UV] = uv_d;
      gs_d[GS_LE] = le_d;
      gs_d[GS_SPI] = spi_d;
   end
   wire gef_d = spi_d | le_d | uv_d | ov_d | ~power_on_reset_not_flag_d | tsd_d | tpw_d;

   // ------------------------------------------------------------
   // Registers and pin outputs
   // ------------------------------------------------------------
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RESET) begin
         {hs_oc_q, ls_oc_q, hs_ol_q, ls_ol_q} <= '0;
         {tpw_q, tsd_q, uv_q, ov_q, spi_q} <= '0;
         power_on_reset_not_flag_q <= 1'b0;
         O_HS_DRIVE <= '0;
         O_LS_DRIVE <= '0;
         O_HS_DRIVE_OE <= '0;
         O_LS_DRIVE_OE <= '0;
         O_GLOBAL_STATUS_ONE <= GS_RESET;
         O_HIGH_SWITCH_OVERCURRENT <= '0;
         O_LOW_SWITCH_OVERCURRENT <= '0;
         O_HIGH_SWITCH_OPEN_LOAD <= '0;
         O_LOW_SWITCH_OPEN_LOAD <= '0;
         O_GLOBAL_FAULT_FLAG <= 1'b1;
      end else if (I_CE) begin
         hs_oc_q <= hs_oc_d;
         ls_oc_q <= ls_oc_d;
         hs_ol_q <= hs_ol_d;
         ls_ol_q <= ls_ol_d;
         tpw_q <= tpw_d;
         tsd_q <= tsd_d;
         uv_q <= uv_d;
         ov_q <= ov_d;
         spi_q <= spi_d;
         power_on_reset_not_flag_q <= power_on_reset_not_flag_d;
         // Bridge driven actively whenever either switch is on
         O_HS_DRIVE <= hs_on & ~hs_fault_off;
         O_LS_DRIVE <= ls_on & ~ls_fault_off;
         O_HS_DRIVE_OE <= (hs_on & ~hs_fault_off) | (ls_on & ~ls_fault_off);
         O_LS_DRIVE_OE <= (hs_on & ~hs_fault_off) | (ls_on & ~ls_fault_off);
         O_GLOBAL_STATUS_ONE <= gs_d;
         O_HIGH_SWITCH_OVERCURRENT <= hs_oc_d;
         O_LOW_SWITCH_OVERCURRENT <= ls_oc_d;
         O_HIGH_SWITCH_OPEN_LOAD <= hs_ol_d;
         O_LOW_SWITCH_OPEN_LOAD <= ls_ol_d;
         O_GLOBAL_FAULT_FLAG <= gef_d;
      end
   end
endmodule

// file: hw/hbfm_pkg.sv
package hbfm_pkg;
   localparam int NUM_HB = 6;
   localparam int NUM_LED_HS = 2;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int DEAD_TIME_NS = 200;
   localparam int DEAD_CYC = (DEAD_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   localparam int OL_FILT_US = 2000;
   localparam int OL_FILT_LED_US = 200;
   localparam int OL_CNT_W = 20;
   localparam int DEAD_CNT_W = 8;
   // ------------------------------------------------------------
   // Global status byte layout
   // ------------------------------------------------------------
   localparam int GS_TPW = 1;
   localparam int GS_TSD = 2;
   localparam int GS_POWER_ON_RESET_NOT_FLAG = 3;
   localparam int GS_OV = 4;
   localparam int GS_UV = 5;
   localparam int GS_LE = 6;
   localparam int GS_SPI = 7;
   localparam logic [7:0] GS_RESET = 8'h0_0;
   // ------------------------------------------------------------
   // Dead-time sequencer states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      HBFM_OFF = 3'b001,
      HBFM_DEAD = 3'b010,
      HBFM_ON = 3'b100
   } hbfm_leg_t;
endpackage

// file: hw/hbfm_leg.sv
`timescale 1ns/1ps
// Dead-time sequencer for one half-bridge
module hbfm_leg
   import hbfm_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_hs_req,
   input wire logic i_ls_req,
   output logic o_hs_on,
   output logic o_ls_on
);
   hbfm_leg_t st_q;
   logic [DEAD_CNT_W-1:0] cnt_q;
   logic sel_hs_q;
   // Both requested together means nothing: never cross-conduct
   wire want_hs = i_hs_req & ~i_ls_req;
   wire want_ls = i_ls_req & ~i_hs_req;
   wire want_any = want_hs | want_ls;
   wire changed = (sel_hs_q != want_hs) || !want_any;
   wire dead_done = cnt_q == DEAD_CNT_W'(DEAD_CYC - 1);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_q <= HBFM_OFF;
         cnt_q <= '0;
         sel_hs_q <= 1'b0;
         o_hs_on <= 1'b0;
         o_ls_on <= 1'b0;
      end else if (i_ce) begin
         case (st_q)
            HBFM_OFF: begin
               cnt_q <= '0;
               if (want_any) begin
                  sel_hs_q <= want_hs;
                  st_q <= HBFM_DEAD;
               end
            end
            HBFM_DEAD: begin
               if (!want_any || sel_hs_q != want_hs) begin
                  st_q <= HBFM_OFF;
               end else if (dead_done) begin
                  st_q <= HBFM_ON;
                  o_hs_on <= sel_hs_q;
                  o_ls_on <= ~sel_hs_q;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            HBFM_ON: begin
               if (changed) begin
                  o_hs_on <= 1'b0;
                  o_ls_on <= 1'b0;
                  st_q <= HBFM_OFF;
               end
            end
            default: begin
               st_q <= HBFM_OFF;
               o_hs_on <= 1'b0;
               o_ls_on <= 1'b0;
            end
         endcase
      end
   end
endmodule

// file: tb/hbfm_top_properties.sv
`timescale 1ns/1ps
module hbfm_top_properties
   import hbfm_pkg::*;
#(
   parameter int OL_FILT_CYC = 20,
   parameter int OL_FILT_LED_CYC = 5
) (
   input wire logic I_SYS_CLK,
   input wire logic I_RESET,
   input wire logic [NUM_HB-1:0] I_HS_OVERCURRENT,
   input wire logic I_TEMP_WARN,
   input wire logic I_TEMP_SHUTDOWN,
   input wire logic I_SUPPLY_LOW,
   input wire logic I_SUPPLY_HIGH,
   input wire logic [NUM_HB-1:0] O_HS_DRIVE,
   input wire logic [NUM_HB-1:0] O_LS_DRIVE,
   input wire logic [NUM_HB-1:0] O_HS_DRIVE_OE,
   input wire logic [7:0] O_GLOBAL_STATUS_ONE,
   input wire logic [NUM_HB-1:0] O_HIGH_SWITCH_OVERCURRENT,
   input wire logic O_GLOBAL_FAULT_FLAG
);
   default clocking @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RESET);
   sequence s_off; O_HS_DRIVE == '0 && O_LS_DRIVE == '0; endsequence
   sequence s_ls_quiet; !O_LS_DRIVE[0] [*8]; endsequence
   property p_no_cross; (O_HS_DRIVE & O_LS_DRIVE) == '0; endproperty
   a_no_cross: assert property (p_no_cross) else $error("cross on");
   property p_dead; $fell(O_HS_DRIVE[0]) |-> s_ls_quiet; endproperty
   a_dead: assert property (p_dead) else $error("no dead time");
   property p_oc;
      I_HS_OVERCURRENT[0] && O_HS_DRIVE[0] |=> !O_HS_DRIVE[0]
         && O_HIGH_SWITCH_OVERCURRENT[0] && O_GLOBAL_STATUS_ONE[GS_LE];
   endproperty
   a_oc: assert property (p_oc) else $error("overcurrent");
   property p_tpw; I_TEMP_WARN |=> O_GLOBAL_STATUS_ONE[GS_TPW]; endproperty
   a_tpw: assert property (p_tpw) else $error("warn flag");
   property p_tsd;
      I_TEMP_SHUTDOWN |=> O_GLOBAL_STATUS_ONE[GS_TSD] ##0 s_off;
   endproperty
   a_tsd: assert property (p_tsd) else $error("shutdown");
   property p_tsd_hold; O_GLOBAL_STATUS_ONE[GS_TSD] |-> s_off; endproperty
   a_tsd_hold: assert property (p_tsd_hold) else $error("tsd drive");
   property p_uv; I_SUPPLY_LOW |=> O_GLOBAL_STATUS_ONE[GS_UV] ##0 s_off;
   endproperty
   a_uv: assert property (p_uv) else $error("supply low");
   property p_ov; I_SUPPLY_HIGH |=> O_GLOBAL_STATUS_ONE[GS_OV] ##0 s_off;
   endproperty
   a_ov: assert property (p_ov) else $error("supply high");
   property p_gef;
      O_GLOBAL_FAULT_FLAG == ((|(O_GLOBAL_STATUS_ONE & 8'hF6))
         || !O_GLOBAL_STATUS_ONE[GS_POWER_ON_RESET_NOT_FLAG]);
   endproperty
   a_gef: assert property (p_gef) else $error("fault flag");
   property p_reset;
      disable iff (1'b0) I_RESET |=> O_HS_DRIVE_OE == '0
         && O_GLOBAL_STATUS_ONE == 8'h00 && O_GLOBAL_FAULT_FLAG;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state");
endmodule

bind hbfm_top hbfm_top_properties #(.OL_FILT_CYC(OL_FILT_CYC),
   .OL_FILT_LED_CYC(OL_FILT_LED_CYC)) u_props (.I_SYS_CLK(I_SYS_CLK),
   .I_RESET(I_RESET), .I_HS_OVERCURRENT(I_HS_OVERCURRENT),
   .I_TEMP_WARN(I_TEMP_WARN), .I_TEMP_SHUTDOWN(I_TEMP_SHUTDOWN),
   .I_SUPPLY_LOW(I_SUPPLY_LOW), .I_SUPPLY_HIGH(I_SUPPLY_HIGH),
   .O_HS_DRIVE(O_HS_DRIVE), .O_LS_DRIVE(O_LS_DRIVE),
   .O_HS_DRIVE_OE(O_HS_DRIVE_OE), .O_GLOBAL_STATUS_ONE(O_GLOBAL_STATUS_ONE),
   .O_HIGH_SWITCH_OVERCURRENT(O_HIGH_SWITCH_OVERCURRENT),
   .O_GLOBAL_FAULT_FLAG(O_GLOBAL_FAULT_FLAG));

// file: tb/hbfm_mcu_model.sv
`timescale 1ns/1ps
module hbfm_mcu_model
   import hbfm_pkg::*;
(
   input wire logic i_clk,
   output logic o_stb,
   output logic [7:0] o_glb,
   output logic [NUM_HB-1:0] o_hoc,
   output logic [NUM_HB-1:0] o_loc,
   output logic [NUM_HB-1:0] o_hol,
   output logic [NUM_HB-1:0] o_lol
);
   initial begin
      o_stb = 1'b0;
      {o_glb, o_hoc, o_loc, o_hol, o_lol} = '1;
   end
   task clr(input logic [7:0] g, input logic [NUM_HB-1:0] hc, lc, ho, lo);
      @(posedge i_clk);
      #1;
      o_stb = 1'b1;
      {o_glb, o_hoc, o_loc, o_hol, o_lol} = {g, hc, lc, ho, lo};
      @(posedge i_clk);
      #1;
      o_stb = 1'b0;
      // Masks mean nothing without the strobe, so scramble them
      {o_glb, o_hoc, o_loc, o_hol, o_lol} = ~{g, hc, lc, ho, lo};
   endtask
endmodule

// file: tb/tb_hbfm_top.sv
`timescale 1ns/1ps
module tb_hbfm_top
   import hbfm_pkg::*;
;
   localparam int OL = 20;
   localparam int LED = 5;
   localparam int W = DEAD_CYC + 10;
   logic clk = 0, rst = 1, den = 0, tw = 0, ts = 0, uv = 0, ov = 0, se = 0;
   logic [5:0] hen = 0, len = 0, hoc = 0, loc = 0, luc = 0, lfw = 0, hled = 0;
   logic [1:0] lsel = 0;
   logic [5:0] hd, ld, hoe, loe, hocq, locq, holq, lolq, ch, cl, co, cq;
   logic [7:0] gs, cg;
   logic global_fault_flag, cs;
   int failures = 0, check_count = 0;
   always #2.5 clk = ~clk;
   hbfm_mcu_model u_mcu (.i_clk(clk), .o_stb(cs), .o_glb(cg), .o_hoc(ch),
      .o_loc(cl), .o_hol(co), .o_lol(cq));
   hbfm_top #(.OL_FILT_CYC(OL), .OL_FILT_LED_CYC(LED)) dut (
      .I_SYS_CLK(clk), .I_RESET(rst), .I_CE(1'b1),
      .I_HIGH_SWITCH_ENABLE(hen), .I_LOW_SWITCH_ENABLE(len),
      .I_HS_PWM_ON(6'h3F), .I_LS_PWM_ON(6'h3F), .I_HS_FREEWHEEL(6'h00),
      .I_LS_FREEWHEEL(lfw), .I_LED_OL_SEL(lsel), .I_HS_OVERCURRENT(hoc),
      .I_LS_OVERCURRENT(loc), .I_HS_UNDERCURRENT(6'h00),
      .I_LS_UNDERCURRENT(luc), .I_HS_UNDERCURRENT_LED(hled),
      .I_TEMP_WARN(tw), .I_TEMP_SHUTDOWN(ts), .I_SUPPLY_LOW(uv),
      .I_SUPPLY_HIGH(ov), .I_SPI_ERROR(se), .I_DEVICE_ENABLE(den),
      .I_CLEAR_STROBE(cs), .I_CLEAR_GLOBAL(cg), .I_CLEAR_HS_OC(ch),
      .I_CLEAR_LS_OC(cl), .I_CLEAR_HS_OL(co), .I_CLEAR_LS_OL(cq),
      .O_HS_DRIVE(hd), .O_LS_DRIVE(ld), .O_HS_DRIVE_OE(hoe),
      .O_LS_DRIVE_OE(loe), .O_GLOBAL_STATUS_ONE(gs),
      .O_HIGH_SWITCH_OVERCURRENT(hocq), .O_LOW_SWITCH_OVERCURRENT(locq),
      .O_HIGH_SWITCH_OPEN_LOAD(holq), .O_LOW_SWITCH_OPEN_LOAD(lolq),
      .O_GLOBAL_FAULT_FLAG(global_fault_flag));
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("wrong value at %0t: %h expected %h", $time, s, e);
      end
   endtask
   task conclude;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #20000;
      failures++;
      conclude();
   end
   initial begin
      step(4);
      rst = 0;
      chk(gs, 8'h00); chk(global_fault_flag, 1); chk(hoe, 0);
      chk(loe, 0);
      u_mcu.clr(8'h08, '0, '0, '0, '0);
      chk(gs[3], 0);
      den = 1;
      u_mcu.clr(8'h08, '0, '0, '0, '0);
      chk(gs, 8'h08); chk(global_fault_flag, 0);
      hen[0] = 1;
      step(30); chk(hd[0], 0);
      step(20); chk(hd, 6'h01);
      chk(hoe, 6'h01); chk(loe, 6'h01);
      hoc[0] = 1;
      step(1);
      hoc[0] = 0;
      chk(hd[0], 0); chk(hocq, 6'h01); chk(gs[6], 1);
      step(W); chk(hd[0], 0); chk(loe[0], 0);
      hoc[0] = 1;
      u_mcu.clr('0, 6'h01, '0, '0, '0); chk(hocq[0], 1);
      hoc[0] = 0;
      u_mcu.clr(8'h40, 6'h01, '0, '0, '0); chk(hocq, 0);
      step(W); chk(hd[0], 1);
      tw = 1;
      step(1); chk(gs[1], 1); chk(hd[0], 1);
      u_mcu.clr(8'h02, '0, '0, '0, '0); chk(gs[1], 1);
      tw = 0;
      u_mcu.clr(8'h02, '0, '0, '0, '0); chk(gs[1], 0);
      ts = 1;
      step(2);
      ts = 0;
      chk(hd, 0); chk(gs[2], 1);
      step(W); chk(hd, 0); chk(hoe, 0);
      u_mcu.clr(8'h04, '0, '0, '0, '0); chk(gs[2], 0);
      step(W); chk(hd[0], 1);
      for (int i = 0; i < 2; i++) begin
         uv = (i == 0);
         ov = (i == 1);
         step(3); chk(hd, 0); chk(gs[5-i], 1);
         uv = 0;
         ov = 0;
         step(W); chk(hd[0], 1); chk(gs[5-i], 1);
         u_mcu.clr(8'h20 >> i, '0, '0, '0, '0); chk(gs[5-i], 0);
      end
      se = 1;
      step(1);
      se = 0;
      chk(global_fault_flag, 1);
      u_mcu.clr(8'h80, '0, '0, '0, '0); chk(global_fault_flag, 0);
      lsel[0] = 1;
      hled[0] = 1;
      step(LED + 3); chk(holq, 6'h01); chk(hd[0], 1);
      hled[0] = 0;
      u_mcu.clr(8'h40, '0, '0, 6'h01, '0); chk(holq, 0);
      lsel[0] = 0;
      hled[0] = 1;
      step(LED + 3); chk(holq, 0);
      hled[0] = 0;
      len[1] = 1;
      step(W);
      luc[1] = 1;
      step(OL - 3);
      luc[1] = 0;
      step(1); chk(lolq, 0);
      luc[1] = 1;
      step(OL + 3); chk(lolq, 6'h02); chk(ld[1], 1);
      luc[1] = 0;
      u_mcu.clr(8'h40, '0, '0, '0, 6'h02); chk(lolq, 0);
      lfw[1] = 1;
      luc[1] = 1;
      step(OL + 3); chk(lolq, 0);
      hen[0] = 0;
      len[0] = 1;
      step(30); chk({hd[0], ld[0]}, 2'b00);
      step(20); chk(ld[0], 1);
      loc[0] = 1;
      step(1);
      loc[0] = 0;
      chk(locq, 6'h01); chk(ld[0], 0); chk(global_fault_flag, 1);
      conclude();
   end
endmodule
